// [address_data_mode_ports_defines.vh]
// constants for the upper-address and data-bus port block
// assumes a 32-bit AXI4-Lite slave with word-per-register addressing
`ifndef ADDRESS_DATA_MODE_PORTS_DEFINES_VH
`define ADDRESS_DATA_MODE_PORTS_DEFINES_VH

// register indexes; byte address is four times the index
`define LOWER_PULLUP_IDX   16'hFFAC
`define UPPER_PULLUP_IDX   16'hFFAD
`define DATA_PULLUP_IDX    16'hFFAE
`define LOWER_DIR_IDX      16'hFFB0
`define UPPER_DIR_IDX      16'hFFB1
`define UPPER_OUT_IDX      16'hFFB3
`define DATA_DIR_IDX       16'hFFB4
`define DATA_OUT_IDX       16'hFFB6

`define AXI_ADDR_W         18
`define IDX_MSB            17
`define IDX_LSB            2

// reset and hardware-standby values
`define PORT_RST           8'h00
// write-only direction registers read back as all ones
`define DIR_READ_VAL       8'hFF
`define MODE1_DIR_VAL      8'hFF

// operating mode strap codes
`define MODE_EXP_ROM_OFF   2'h1
`define MODE_EXP_ROM_ON    2'h2

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// [address_data_mode_ports.v]
// upper-address / data-bus mode-multiplexed ports with register file
// assumes the bus controller runs on clk_sys_i and pins feed pad cells
`timescale 1ns/10ps
`include "address_data_mode_ports_defines.vh"

module address_data_mode_ports #(
   parameter PORT_W = 8
) (
   input  wire                   clk_sys_i,
   input  wire                   arst_n_i,
   input  wire [1:0]             mode_i,
   input  wire                   hw_standby_i,
   input  wire                   sw_standby_i,
   input  wire                   host_if_enable_i,
   input  wire [PORT_W-1:0]      upper_address_lines_i,
   input  wire [PORT_W-1:0]      external_data_lines_i,
   input  wire                   external_data_drive_i,
   output wire [PORT_W-1:0]      external_data_lines_o,
   input  wire [PORT_W-1:0]      upper_pin_i,
   output wire [PORT_W-1:0]      upper_pin_o,
   output wire [PORT_W-1:0]      upper_pin_oe_n_o,
   input  wire [PORT_W-1:0]      data_pin_i,
   output wire [PORT_W-1:0]      data_pin_o,
   output wire [PORT_W-1:0]      data_pin_oe_n_o,
   output wire [PORT_W-1:0]      upper_pullup_o,
   output wire [PORT_W-1:0]      data_pullup_o,
   output wire [PORT_W-1:0]      lower_pullup_o,
   input  wire [`AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire [2:0]             s_axi_awprot,
   input  wire                   s_axi_awvalid,
   output wire                   s_axi_awready,
   input  wire [31:0]            s_axi_wdata,
   input  wire [3:0]             s_axi_wstrb,
   input  wire                   s_axi_wvalid,
   output wire                   s_axi_wready,
   output reg  [1:0]             s_axi_bresp,
   output reg                    s_axi_bvalid,
   input  wire                   s_axi_bready,
   input  wire [`AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire [2:0]             s_axi_arprot,
   input  wire                   s_axi_arvalid,
   output wire                   s_axi_arready,
   output reg  [31:0]            s_axi_rdata,
   output reg  [1:0]             s_axi_rresp,
   output reg                    s_axi_rvalid,
   input  wire                   s_axi_rready
);

   // synchronisers for pin inputs
   reg  [PORT_W-1:0]      upper_pin_m;
   reg  [PORT_W-1:0]      upper_pin_s;
   reg  [PORT_W-1:0]      data_pin_m;
   reg  [PORT_W-1:0]      data_pin_s;
   reg                    hw_stby_m;
   reg                    hw_stby_s;
   reg  [1:0]             mode_m;
   reg  [1:0]             mode_s;
   reg  [1:0]             sync_fill;

   // strapped mode, one-hot: bit0 mode 1, bit1 mode 2, bit2 mode 3
   reg  [2:0]             mode_oh;
   reg                    mode_taken;

   reg  [PORT_W-1:0]      upper_direction;
   reg  [PORT_W-1:0]      upper_port_output_data;
   reg  [PORT_W-1:0]      upper_port_pullup_enable;
   reg  [PORT_W-1:0]      data_port_direction;
   reg  [PORT_W-1:0]      data_port_output_data;
   reg  [PORT_W-1:0]      data_port_pullup_enable;
   // lower port registers exist only to steer its pull-ups
   reg  [PORT_W-1:0]      lower_port_direction;
   reg  [PORT_W-1:0]      lower_port_pullup_enable;

   reg                    aw_held;
   reg  [`AXI_ADDR_W-1:0] aw_addr;
   reg                    w_held;
   reg  [31:0]            w_data;
   reg                    w_lane0;

   wire                   mode1;
   wire                   mode2;
   wire                   expanded;
   wire [PORT_W-1:0]      upper_dir_eff;
   reg  [PORT_W-1:0]      upper_addr_drv;
   reg  [PORT_W-1:0]      upper_gen_drv;
   reg  [PORT_W-1:0]      data_gen_drv;
   reg                    bus_drive;
   wire                   do_write;
   wire [15:0]            wr_idx;
   wire [15:0]            rd_idx;
   wire [PORT_W-1:0]      wr_byte;
   wire [PORT_W-1:0]      upper_read;
   wire [PORT_W-1:0]      data_read;
   reg  [PORT_W-1:0]      next_rdata;
   reg                    next_rmapped;
   reg                    wr_mapped;
   // pull-up steering, one word per port
   reg  [PORT_W-1:0]      upper_pu;
   reg  [PORT_W-1:0]      data_pu;
   reg  [PORT_W-1:0]      lower_pu;

   // pins, strap and hw standby come from outside the clock domain
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         upper_pin_m <= `PORT_RST;
         upper_pin_s <= `PORT_RST;
         data_pin_m  <= `PORT_RST;
         data_pin_s  <= `PORT_RST;
         hw_stby_m   <= 1'b0;
         hw_stby_s   <= 1'b0;
         mode_m      <= 2'h0;
         mode_s      <= 2'h0;
         sync_fill   <= 2'h0;
      end else begin
         upper_pin_m <= upper_pin_i;
         upper_pin_s <= upper_pin_m;
         data_pin_m  <= data_pin_i;
         data_pin_s  <= data_pin_m;
         hw_stby_m   <= hw_standby_i;
         hw_stby_s   <= hw_stby_m;
         mode_m      <= mode_i;
         mode_s      <= mode_m;
         sync_fill   <= {sync_fill[0], 1'b1};
      end
   end

   // strap caught once the synchroniser holds a post-reset sample
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_oh    <= 3'h0;
         mode_taken <= 1'b0;
      end else if (sync_fill[1] && !mode_taken) begin
         mode_taken <= 1'b1;
         if (mode_s == `MODE_EXP_ROM_OFF) begin
            mode_oh <= 3'b001;
         end else if (mode_s == `MODE_EXP_ROM_ON) begin
            mode_oh <= 3'b010;
         end else begin
            mode_oh <= 3'b100;
         end
      end
   end

   assign mode1    = mode_oh[0];
   assign mode2    = mode_oh[1];
   assign expanded = mode1 | mode2;

   // pin drive by strapped mode; nothing drives before the strap is caught,
   // and hw standby gates the drive so pins float from the first synced cycle
   always @* begin
      upper_addr_drv = {PORT_W{1'b0}};
      upper_gen_drv  = {PORT_W{1'b0}};
      data_gen_drv   = {PORT_W{1'b0}};
      bus_drive      = 1'b0;
      case (mode_oh)
         3'b001: begin
            if (!hw_stby_s) begin
               upper_addr_drv = {PORT_W{1'b1}};
            end
            bus_drive = external_data_drive_i && !hw_stby_s && !sw_standby_i;
         end
         3'b010: begin
            upper_addr_drv = upper_direction;
            bus_drive = external_data_drive_i && !hw_stby_s && !sw_standby_i;
         end
         3'b100: begin
            upper_gen_drv = upper_direction;
            if (!hw_stby_s) begin
               data_gen_drv = data_port_direction;
            end
         end
         default: begin
            upper_addr_drv = {PORT_W{1'b0}};
         end
      endcase
   end

   assign upper_dir_eff  = mode1 ? `MODE1_DIR_VAL : upper_direction;
   assign upper_pin_oe_n_o = ~((upper_addr_drv | upper_gen_drv) &
                               {PORT_W{!hw_stby_s}});
   assign upper_pin_o = (upper_address_lines_i & upper_addr_drv) |
                        (upper_port_output_data & ~upper_addr_drv);

   // data port: bus in expanded modes, general i/o in mode 3
   assign data_pin_oe_n_o = ~(data_gen_drv | {PORT_W{bus_drive}});
   assign data_pin_o = expanded ? external_data_lines_i : data_port_output_data;
   assign external_data_lines_o = data_pin_s;

   // pull-ups only on input pins; all off before the strap and in hw standby
   always @* begin
      upper_pu = {PORT_W{1'b0}};
      data_pu  = {PORT_W{1'b0}};
      lower_pu = {PORT_W{1'b0}};
      if (!hw_stby_s) begin
         case (mode_oh)
            3'b001: begin
               lower_pu = {PORT_W{1'b0}};
            end
            3'b010: begin
               upper_pu = upper_port_pullup_enable & ~upper_direction;
               lower_pu = lower_port_pullup_enable & ~lower_port_direction;
            end
            3'b100: begin
               upper_pu = upper_port_pullup_enable & ~upper_direction;
               lower_pu = lower_port_pullup_enable & ~lower_port_direction;
               if (!host_if_enable_i) begin
                  data_pu = data_port_pullup_enable & ~data_port_direction;
               end
            end
            default: begin
               upper_pu = {PORT_W{1'b0}};
            end
         endcase
      end
   end

   assign upper_pullup_o = upper_pu;
   assign data_pullup_o  = data_pu;
   assign lower_pullup_o = lower_pu;

   // port reads mix stored data and live pins per direction bit
   assign upper_read = (upper_port_output_data & upper_dir_eff) |
                       (upper_pin_s & ~upper_dir_eff);
   assign data_read  = (data_port_output_data & data_port_direction) |
                       (data_pin_s & ~data_port_direction);

   // AXI4-Lite write side: address and data accepted in either order
   // ready drops while an item is held or the answer waits: one write at a time
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;
   assign wr_idx        = aw_addr[`IDX_MSB:`IDX_LSB];
   assign wr_byte       = w_data[PORT_W-1:0];

   // unmapped indexes answer with an error and change nothing
   always @* begin
      case (wr_idx)
         `LOWER_PULLUP_IDX, `UPPER_PULLUP_IDX, `DATA_PULLUP_IDX,
         `LOWER_DIR_IDX, `UPPER_DIR_IDX, `UPPER_OUT_IDX,
         `DATA_DIR_IDX, `DATA_OUT_IDX: wr_mapped = 1'b1;
         default: wr_mapped = 1'b0;
      endcase
   end

   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         aw_held      <= 1'b0;
         aw_addr      <= {`AXI_ADDR_W{1'b0}};
         w_held       <= 1'b0;
         w_data       <= 32'h00000000;
         w_lane0      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // register file; hw standby clears everything, sw standby changes nothing
   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         upper_direction          <= `PORT_RST;
         upper_port_output_data   <= `PORT_RST;
         upper_port_pullup_enable <= `PORT_RST;
         data_port_direction      <= `PORT_RST;
         data_port_output_data    <= `PORT_RST;
         data_port_pullup_enable  <= `PORT_RST;
         lower_port_direction     <= `PORT_RST;
         lower_port_pullup_enable <= `PORT_RST;
      end else if (hw_stby_s) begin
         upper_direction          <= `PORT_RST;
         upper_port_output_data   <= `PORT_RST;
         upper_port_pullup_enable <= `PORT_RST;
         data_port_direction      <= `PORT_RST;
         data_port_output_data    <= `PORT_RST;
         data_port_pullup_enable  <= `PORT_RST;
         lower_port_direction     <= `PORT_RST;
         lower_port_pullup_enable <= `PORT_RST;
      end else if (do_write && w_lane0) begin
         case (wr_idx)
            `LOWER_PULLUP_IDX: lower_port_pullup_enable <= wr_byte;
            `UPPER_PULLUP_IDX: upper_port_pullup_enable <= wr_byte;
            `DATA_PULLUP_IDX:  data_port_pullup_enable  <= wr_byte;
            `LOWER_DIR_IDX: begin
               if (!mode1) begin
                  lower_port_direction <= wr_byte;
               end
            end
            `UPPER_DIR_IDX: begin
               if (!mode1) begin
                  upper_direction <= wr_byte;
               end
            end
            `UPPER_OUT_IDX:    upper_port_output_data <= wr_byte;
            `DATA_DIR_IDX:     data_port_direction    <= wr_byte;
            `DATA_OUT_IDX:     data_port_output_data  <= wr_byte;
            default: begin
            end
         endcase
      end
   end

   // AXI4-Lite read side: one-cycle answer
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_idx        = s_axi_araddr[`IDX_MSB:`IDX_LSB];

   always @* begin
      next_rdata   = `PORT_RST;
      next_rmapped = 1'b1;
      case (rd_idx)
         `LOWER_PULLUP_IDX: next_rdata = lower_port_pullup_enable;
         `UPPER_PULLUP_IDX: next_rdata = upper_port_pullup_enable;
         `DATA_PULLUP_IDX:  next_rdata = data_port_pullup_enable;
         `LOWER_DIR_IDX:    next_rdata = `DIR_READ_VAL;
         `UPPER_DIR_IDX:    next_rdata = `DIR_READ_VAL;
         `UPPER_OUT_IDX:    next_rdata = upper_read;
         `DATA_DIR_IDX:     next_rdata = `DIR_READ_VAL;
         `DATA_OUT_IDX:     next_rdata = data_read;
         default:           next_rmapped = 1'b0;
      endcase
   end

   always @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {{(32-PORT_W){1'b0}}, next_rdata};
         s_axi_rresp  <= next_rmapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // address_data_mode_ports

// [pad_model.sv]
// pad and far-side device model for one 8-bit port
// assumes oe_n low means the block drives the pad
`timescale 1ns/10ps
module pad_model (
   input  wire       clk_sys_i,
   input  wire [7:0] pad_o_i,
   input  wire [7:0] oe_n_i,
   input  wire [7:0] pullup_i,
   input  wire       ext_en_i,
   input  wire [7:0] ext_val_i,
   output wire [7:0] pad_level_o
);
   reg  [7:0] churn = 8'h5A;
   wire [7:0] far;

   // an undriven pad with no pull-up toggles bits 7:6 and 1:0 every cycle; bits 5:2 hold still
   always @(posedge clk_sys_i) begin
      churn <= ~churn ^ 8'h3C;
   end
   assign far = ext_en_i ? ext_val_i : (pullup_i | churn);
   assign pad_level_o = (~oe_n_i & pad_o_i) | (oe_n_i & far);
endmodule // pad_model

// [address_data_mode_ports_properties.sv]
// assertion checker for the mode-multiplexed port block
// assumes mode_i is a strap that changes only while reset is low
`timescale 1ns/10ps
module address_data_mode_ports_properties (
   input wire       clk_sys_i,
   input wire       arst_n_i,
   input wire [1:0] mode_i,
   input wire       hw_standby_i,
   input wire       sw_standby_i,
   input wire       host_if_enable_i,
   input wire [7:0] upper_address_lines_i,
   input wire [7:0] upper_pin_o,
   input wire [7:0] upper_pin_oe_n_o,
   input wire [7:0] data_pin_oe_n_o,
   input wire [7:0] upper_pullup_o,
   input wire [7:0] data_pullup_o,
   input wire [7:0] lower_pullup_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   a_upper_pullup_input: assert property ((upper_pullup_o & ~upper_pin_oe_n_o) == 8'h00)
      else $error("upper pull-up on a driven pin");
   a_data_pullup_input: assert property ((data_pullup_o & ~data_pin_oe_n_o) == 8'h00)
      else $error("data pull-up on a driven pin");
   a_mode1_upper_pullup: assert property (mode_i == 2'h1 |-> upper_pullup_o == 8'h00)
      else $error("upper pull-up on in mode 1");
   a_expanded_data_pullup: assert property (mode_i inside {2'h1, 2'h2} |-> data_pullup_o == 8'h00)
      else $error("data pull-up on in expanded mode");
   a_host_if_pullup: assert property (host_if_enable_i |-> data_pullup_o == 8'h00)
      else $error("data pull-up on with host interface");
   a_mode1_lower_pullup: assert property (mode_i == 2'h1 |-> lower_pullup_o == 8'h00)
      else $error("lower pull-up on in mode 1");
   // strap capture and standby sync both settle inside five cycles
   a_mode1_address_out: assert property ((mode_i == 2'h1 && !hw_standby_i) [*5] |->
      upper_pin_oe_n_o == 8'h00 && upper_pin_o == upper_address_lines_i)
      else $error("mode 1 upper port not driving address");
   a_hw_standby_float: assert property (hw_standby_i [*4] |-> upper_pin_oe_n_o == 8'hFF &&
      data_pin_oe_n_o == 8'hFF && upper_pullup_o == 8'h00)
      else $error("pins not floating in hardware standby");
   a_sw_standby_bus: assert property ((mode_i inside {2'h1, 2'h2} && sw_standby_i) [*2] |->
      data_pin_oe_n_o == 8'hFF)
      else $error("data bus driven in software standby");
endmodule // address_data_mode_ports_properties

bind address_data_mode_ports address_data_mode_ports_properties u_props (
   .clk_sys_i, .arst_n_i, .mode_i, .hw_standby_i, .sw_standby_i, .host_if_enable_i,
   .upper_address_lines_i, .upper_pin_o, .upper_pin_oe_n_o, .data_pin_oe_n_o,
   .upper_pullup_o, .data_pullup_o, .lower_pullup_o);

// [tb_top.sv]
// self-checking bench for the mode-multiplexed ports over AXI4-Lite
// assumes pad_model on both ports and mode changes only under reset
`timescale 1ns/10ps
`include "address_data_mode_ports_defines.vh"
module tb_top;
   reg         clk_sys_i = 1'b0, arst_n_i = 1'b0, hw_standby_i = 1'b0, sw_standby_i = 1'b0;
   reg         host_if_enable_i = 1'b0, external_data_drive_i = 1'b0, ext_en = 1'b0;
   reg  [1:0]  mode_i = 2'h3;
   reg  [7:0]  upper_address_lines_i = 8'hC6, external_data_lines_i = 8'h93, ext_val = 8'h69;
   reg  [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire [7:0]  external_data_lines_o, upper_pin_i, upper_pin_o, upper_pin_oe_n_o;
   wire [7:0]  data_pin_i, data_pin_o, data_pin_oe_n_o, upper_pullup_o, data_pullup_o;
   wire [7:0]  lower_pullup_o;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   integer     num_errors = 0, tests_run = 0;

   always #2.5 clk_sys_i = ~clk_sys_i;

   address_data_mode_ports dut (.clk_sys_i, .arst_n_i, .mode_i, .hw_standby_i, .sw_standby_i,
      .host_if_enable_i, .upper_address_lines_i, .external_data_lines_i, .external_data_drive_i,
      .external_data_lines_o, .upper_pin_i, .upper_pin_o, .upper_pin_oe_n_o, .data_pin_i,
      .data_pin_o, .data_pin_oe_n_o, .upper_pullup_o, .data_pullup_o, .lower_pullup_o,
      .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   pad_model upper_pad (.clk_sys_i, .pad_o_i(upper_pin_o), .oe_n_i(upper_pin_oe_n_o),
      .pullup_i(upper_pullup_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_level_o(upper_pin_i));
   pad_model data_pad (.clk_sys_i, .pad_o_i(data_pin_o), .oe_n_i(data_pin_oe_n_o),
      .pullup_i(data_pullup_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_level_o(data_pin_i));

   task tally_and_finish;
      begin
         if (num_errors == 0 && tests_run > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask

   task chk(input string nm, input [31:0] exp, input [31:0] seen);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask

   task wait_clk(input integer n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   task restart(input [1:0] m);
      begin
         arst_n_i <= 1'b0;
         mode_i   <= m;
         wait_clk(10);
         arst_n_i <= 1'b1;
         wait_clk(5);
      end
   endtask

   // each channel holds valid until its own ready; bready stays up until bvalid
   task axi_wr(input [15:0] idx, input [7:0] d);
      reg aw_ok, w_ok;
      begin
         s_axi_awaddr  <= {idx, 2'b00};
         s_axi_wdata   <= {24'h0, d};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid  <= 1'b1;
         s_axi_bready  <= 1'b1;
         aw_ok = 1'b0;
         w_ok  = 1'b0;
         while (!(aw_ok && w_ok)) begin
            @(posedge clk_sys_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            aw_ok = aw_ok | s_axi_awready;
            w_ok  = w_ok | s_axi_wready;
         end
         do @(posedge clk_sys_i); while (s_axi_bvalid !== 1'b1);
         s_axi_bready <= 1'b0;
         chk("bresp", `RESP_OKAY, s_axi_bresp);
         @(posedge clk_sys_i);
      end
   endtask

   task axi_rd(input [15:0] idx, input [7:0] exp, input [1:0] exp_resp);
      begin
         s_axi_araddr  <= {idx, 2'b00};
         s_axi_arvalid <= 1'b1;
         s_axi_rready  <= 1'b1;
         do @(posedge clk_sys_i); while (s_axi_arready !== 1'b1);
         s_axi_arvalid <= 1'b0;
         do @(posedge clk_sys_i); while (s_axi_rvalid !== 1'b1);
         s_axi_rready <= 1'b0;
         chk("rdata", {24'h0, exp}, s_axi_rdata);
         chk("rresp", exp_resp, s_axi_rresp);
         @(posedge clk_sys_i);
      end
   endtask

   initial begin
      wait_clk(20000);
      num_errors = num_errors + 1;
      tally_and_finish;
   end

   initial begin
      restart(2'h3);
      axi_rd(`UPPER_DIR_IDX, 8'hFF, `RESP_OKAY);
      axi_rd(`DATA_DIR_IDX, 8'hFF, `RESP_OKAY);
      axi_rd(`UPPER_PULLUP_IDX, 8'h00, `RESP_OKAY);
      axi_rd(`DATA_PULLUP_IDX, 8'h00, `RESP_OKAY);
      axi_rd(16'h0010, 8'h00, `RESP_SLVERR);
      axi_wr(`UPPER_DIR_IDX, 8'h0F);
      axi_wr(`UPPER_OUT_IDX, 8'hA5);
      axi_wr(`UPPER_PULLUP_IDX, 8'hFF);
      axi_wr(`DATA_DIR_IDX, 8'hC3);
      axi_wr(`DATA_OUT_IDX, 8'h81);
      axi_wr(`DATA_PULLUP_IDX, 8'hFF);
      wait_clk(4);
      chk("u_oe_n", 8'hF0, upper_pin_oe_n_o);
      chk("u_pin", 8'h05, upper_pin_o & 8'h0F);
      chk("u_pu", 8'hF0, upper_pullup_o);
      chk("d_oe_n", 8'h3C, data_pin_oe_n_o);
      chk("d_pin", 8'h81, data_pin_o & 8'hC3);
      chk("d_pu", 8'h3C, data_pullup_o);
      axi_rd(`UPPER_OUT_IDX, 8'hF5, `RESP_OKAY);
      axi_rd(`DATA_OUT_IDX, 8'hBD, `RESP_OKAY);
      host_if_enable_i <= 1'b1;
      wait_clk(2);
      chk("d_pu_host", 8'h00, data_pullup_o);
      host_if_enable_i <= 1'b0;
      sw_standby_i     <= 1'b1;
      wait_clk(4);
      chk("u_oe_n_sw", 8'hF0, upper_pin_oe_n_o);
      chk("d_oe_n_sw", 8'h3C, data_pin_oe_n_o);
      chk("u_pu_sw", 8'hF0, upper_pullup_o);
      axi_rd(`UPPER_OUT_IDX, 8'hF5, `RESP_OKAY);
      sw_standby_i <= 1'b0;
      hw_standby_i <= 1'b1;
      wait_clk(6);
      hw_standby_i <= 1'b0;
      wait_clk(6);
      chk("u_oe_n_hw", 8'hFF, upper_pin_oe_n_o);
      chk("d_oe_n_hw", 8'hFF, data_pin_oe_n_o);
      axi_rd(`UPPER_PULLUP_IDX, 8'h00, `RESP_OKAY);
      axi_rd(`DATA_PULLUP_IDX, 8'h00, `RESP_OKAY);
      axi_wr(`UPPER_DIR_IDX, 8'hFF);
      axi_wr(`DATA_DIR_IDX, 8'hFF);
      axi_rd(`UPPER_OUT_IDX, 8'h00, `RESP_OKAY);
      axi_rd(`DATA_OUT_IDX, 8'h00, `RESP_OKAY);
      restart(2'h1);
      axi_wr(`UPPER_DIR_IDX, 8'h00);
      axi_wr(`LOWER_PULLUP_IDX, 8'hFF);
      axi_wr(`DATA_PULLUP_IDX, 8'hFF);
      chk("m1_u_oe_n", 8'h00, upper_pin_oe_n_o);
      chk("m1_u_pin", 8'hC6, upper_pin_o);
      chk("m1_l_pu", 8'h00, lower_pullup_o);
      chk("m1_d_pu", 8'h00, data_pullup_o);
      axi_rd(`UPPER_DIR_IDX, 8'hFF, `RESP_OKAY);
      external_data_drive_i <= 1'b1;
      wait_clk(2);
      chk("m1_d_oe_n", 8'h00, data_pin_oe_n_o);
      chk("m1_d_pin", 8'h93, data_pin_o);
      sw_standby_i <= 1'b1;
      wait_clk(3);
      chk("m1_d_oe_sw", 8'hFF, data_pin_oe_n_o);
      sw_standby_i          <= 1'b0;
      external_data_drive_i <= 1'b0;
      ext_en                <= 1'b1;
      wait_clk(4);
      chk("m1_d_in", 8'h69, external_data_lines_o);
      ext_en       <= 1'b0;
      hw_standby_i <= 1'b1;
      wait_clk(5);
      chk("m1_u_oe_hw", 8'hFF, upper_pin_oe_n_o);
      hw_standby_i <= 1'b0;
      restart(2'h2);
      chk("m2_u_oe_n", 8'hFF, upper_pin_oe_n_o);
      axi_wr(`UPPER_DIR_IDX, 8'h81);
      axi_wr(`UPPER_PULLUP_IDX, 8'hFF);
      axi_wr(`LOWER_DIR_IDX, 8'h0F);
      axi_wr(`LOWER_PULLUP_IDX, 8'hFF);
      chk("m2_u_oe_n", 8'h7E, upper_pin_oe_n_o);
      chk("m2_u_pin", 8'h80, upper_pin_o & 8'h81);
      chk("m2_u_pu", 8'h7E, upper_pullup_o);
      chk("m2_l_pu", 8'hF0, lower_pullup_o);
      tally_and_finish;
   end
endmodule // tb_top
